// ===== irsd_addr_decode.sv
/*
 * combinational address sorter for the internal register space.
 * assumes a 32-bit register address from the core; no clock.
 */
`timescale 1ns/1ns
`include "irsd_consts.svh"
module irsd_addr_decode (
    input wire logic [31:0] addr,
    output irsd_pkg::irsd_dec_t dec
);
    import irsd_pkg::*;

    // ==========================================
    // group pattern
    wire logic [2:0] grp_bits = addr[`IRSD_GRP_HI:`IRSD_GRP_LO];
    // only bits 24 and 22 are looked at; other bits alias freely, no fault
    wire logic is_tag = grp_bits[2] & ~grp_bits[0];
    wire logic is_par = grp_bits[2] & grp_bits[0];
    // anything not tag or parity falls into the normal group
    assign dec.grp = is_par ? IRSD_GRP_PARITY : (is_tag ? IRSD_GRP_TAG : IRSD_GRP_NORMAL);
    assign dec.nrm_idx = addr[`IRSD_NRM_HI:0];
    assign dec.tag_idx = addr[`IRSD_TAG_IDX_HI:`IRSD_TAG_IDX_LO];
    assign dec.par_idx = addr[`IRSD_PAR_IDX_HI:`IRSD_PAR_IDX_LO];
endmodule

// ===== irsd_cache_window.sv
/*
 * storage behind one cache window (tag or parity), one word per entry.
 * assumes the caller qualifies wr with the group decode.
 */
`timescale 1ns/1ns
module irsd_cache_window #(
    parameter int AW = 8
) (
    input wire logic mclk,
    input wire logic wr,
    input wire logic [AW-1:0] idx,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata
);
    import irsd_pkg::*;

    logic [31:0] mem [0:(1<<AW)-1];

    // contents are cache state, so no reset
    always_ff @(posedge mclk) begin
        if (wr) begin
            mem[idx] <= wdata;
        end
    end

    // read is combinational so the caller registers it in the request cycle
    assign rdata = mem[idx];
endmodule

// ===== irsd_consts.svh
/*
 * internal register space decoder: address patterns, offsets, fill values.
 * assumes it is included by bare name from the decode and top design files.
 */
`ifndef IRSD_CONSTS_SVH
`define IRSD_CONSTS_SVH

// ==========================================
// group selection and index bits
`define IRSD_GRP_HI 24
`define IRSD_GRP_LO 22
`define IRSD_TAG_IDX_HI 12
`define IRSD_TAG_IDX_LO 5
`define IRSD_PAR_IDX_HI 12
`define IRSD_PAR_IDX_LO 3
`define IRSD_NRM_HI 7

// ==========================================
// normal register offsets
`define IRSD_KSP 8'h00
`define IRSD_ESP 8'h01
`define IRSD_SSP 8'h02
`define IRSD_USP 8'h03
`define IRSD_ISP 8'h04
`define IRSD_R0B 8'h08
`define IRSD_R0L 8'h09
`define IRSD_R1B 8'h0A
`define IRSD_R1L 8'h0B
`define IRSD_STB 8'h0C
`define IRSD_STL 8'h0D
`define IRSD_PNUM 8'h0E
`define IRSD_PBB 8'h10
`define IRSD_CBVB 8'h11
`define IRSD_PRIO 8'h12
`define IRSD_PTL 8'h13
`define IRSD_SIREQ 8'h14
`define IRSD_SISUM 8'h15
`define IRSD_ICC 8'h18
`define IRSD_NIR 8'h19
`define IRSD_ICNT 8'h1A
`define IRSD_TOD 8'h1B
`define IRSD_MCEC 8'h26
`define IRSD_CSC 8'h2A
`define IRSD_CSS 8'h2B
`define IRSD_MME 8'h38
`define IRSD_TFA 8'h39
`define IRSD_TFO 8'h3A
`define IRSD_PME 8'h3D
`define IRSD_SYSID 8'h3E
`define IRSD_TPRB 8'h3F
`define IRSD_ISS 8'h79
`define IRSD_MBX 8'h7A
`define IRSD_PMC 8'h7B
`define IRSD_PSC 8'h7C
`define IRSD_EUC 8'h7D
`define IRSD_TTF 8'h7E
`define IRSD_TEF 8'h7F
`define IRSD_BIC 8'hA0

// ==========================================
// fixed read and reset values
`define IRSD_WO_READ 32'h00000000
`define IRSD_RST_VAL 32'h00000000
// arbitrary neutral identity value
`define IRSD_SYSID_VAL 32'h00000000
`endif

// ===== irsd_core_model.sv
/*
 * core-side model: issues register reads and writes to the bank.
 * assumes the bench calls issue() back to back and idle() at the end.
 */
`timescale 1ns/1ns
module irsd_core_model (
    input wire logic mclk,
    output irsd_pkg::irsd_req_t req
);
    import irsd_pkg::*;

    initial req = '0;

    // ==========================================
    // access tasks
    // callers keep test and diagnostic offsets out of normal traffic
    task automatic issue(input logic rd, input logic wr, input logic [31:0] a,
                         input logic [31:0] d);
        @(posedge mclk);
        req <= '{rd: rd, wr: wr, addr: a, wdata: d};
    endtask

    task automatic idle();
        @(posedge mclk);
        req.rd <= 1'b0;
        req.wr <= 1'b0;
        // released lines must not keep the last value
        req.addr <= ~req.addr;
        req.wdata <= ~req.wdata;
    endtask
endmodule

// ===== irsd_pkg.sv
/*
 * types shared by the decoder files.
 * assumes irsd_consts.svh is on the include path.
 */
package irsd_pkg;
    typedef enum logic [1:0] {
        IRSD_GRP_NORMAL,
        IRSD_GRP_TAG,
        IRSD_GRP_PARITY
    } irsd_group_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } irsd_req_t;

    typedef struct packed {
        irsd_group_t grp;
        logic [7:0] nrm_idx;
        logic [7:0] tag_idx;
        logic [9:0] par_idx;
    } irsd_dec_t;
endpackage

// ===== irsd_top.sv
/*
 * internal register bank with three-way address decode.
 * assumes the core presents one rd or wr per cycle; rdata answers next cycle.
 */
`timescale 1ns/1ns
`include "irsd_consts.svh"
module irsd_top (
    input wire logic mclk,
    input wire logic rst_n,
    input irsd_pkg::irsd_req_t req,
    output logic [31:0] rdata,
    output logic rvalid,
    output irsd_pkg::irsd_group_t rgroup,
    output logic [31:0] reload_value,
    output logic reload_load,
    output logic [31:0] flush_one_addr,
    output logic flush_one,
    output logic flush_all,
    output logic [31:0] mce_clear_data,
    output logic mce_clear,
    output logic [31:0] soft_irq_level,
    output logic soft_irq_req
);
    import irsd_pkg::*;

    // ==========================================
    // decode
    irsd_dec_t dec;
    irsd_addr_decode u_dec (
        .addr(req.addr),
        .dec(dec)
    );

    wire logic sel_nrm = (dec.grp == IRSD_GRP_NORMAL);
    wire logic sel_tag = (dec.grp == IRSD_GRP_TAG);
    wire logic sel_par = (dec.grp == IRSD_GRP_PARITY);
    wire logic nwr = req.wr & sel_nrm;
    wire logic [7:0] ni = dec.nrm_idx;

    // ==========================================
    // cache windows
    logic [31:0] tag_rdata;
    logic [31:0] par_rdata;
    irsd_cache_window #(.AW(8)) u_tag (
        .mclk(mclk),
        .wr(req.wr & sel_tag),
        .idx(dec.tag_idx),
        .wdata(req.wdata),
        .rdata(tag_rdata)
    );
    irsd_cache_window #(.AW(10)) u_par (
        .mclk(mclk),
        .wr(req.wr & sel_par),
        .idx(dec.par_idx),
        .wdata(req.wdata),
        .rdata(par_rdata)
    );

    // ==========================================
    // normal read/write storage
    // a sparse table of read/write registers kept as one array by offset
    localparam int NALL = 26;
    localparam logic [7:0] RW_OFS [0:NALL-1] = '{
        `IRSD_KSP, `IRSD_ESP, `IRSD_SSP, `IRSD_USP, `IRSD_ISP,
        `IRSD_R0B, `IRSD_R0L, `IRSD_R1B, `IRSD_R1L, `IRSD_STB, `IRSD_STL,
        `IRSD_PNUM, `IRSD_PBB, `IRSD_CBVB, `IRSD_PRIO, `IRSD_PTL,
        `IRSD_SISUM, `IRSD_ICC, `IRSD_TOD, `IRSD_MME, `IRSD_PME,
        `IRSD_ISS, `IRSD_MBX, `IRSD_PMC, `IRSD_EUC, `IRSD_BIC
    };

    logic [31:0] rw_r [0:NALL-1];
    logic [NALL-1:0] rw_hit;
    logic [31:0] rw_mux [0:NALL];

    assign rw_mux[0] = `IRSD_WO_READ;
    genvar g;
    generate
        for (g = 0; g < NALL; g++) begin : g_rw
            localparam logic [7:0] OFS = RW_OFS[g];
            assign rw_hit[g] = (ni == OFS);
            assign rw_mux[g+1] = rw_hit[g] ? rw_r[g] : rw_mux[g];
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    rw_r[g] <= `IRSD_RST_VAL;
                end else if (nwr & rw_hit[g]) begin
                    rw_r[g] <= req.wdata;
                end
            end
        end
    endgenerate

    // ==========================================
    // read-only sources
    // counter, saved pc/psl only take the reset value; nothing loads them
    logic [31:0] icnt_r;
    logic [31:0] csc_r;
    logic [31:0] css_r;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            icnt_r <= `IRSD_RST_VAL;
            csc_r <= `IRSD_RST_VAL;
            css_r <= `IRSD_RST_VAL;
        end
    end

    // ==========================================
    // write-only strobes
    wire logic hit_nir = nwr & (ni == `IRSD_NIR);
    wire logic hit_tfo = nwr & (ni == `IRSD_TFO);
    wire logic hit_tfa = nwr & (ni == `IRSD_TFA);
    wire logic hit_mce = nwr & (ni == `IRSD_MCEC);
    wire logic hit_sir = nwr & (ni == `IRSD_SIREQ);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reload_load <= 1'b0;
            flush_one <= 1'b0;
            flush_all <= 1'b0;
            mce_clear <= 1'b0;
            soft_irq_req <= 1'b0;
        end else begin
            reload_load <= hit_nir;
            flush_one <= hit_tfo;
            flush_all <= hit_tfa;
            mce_clear <= hit_mce;
            soft_irq_req <= hit_sir;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reload_value <= `IRSD_RST_VAL;
            flush_one_addr <= `IRSD_RST_VAL;
            mce_clear_data <= `IRSD_RST_VAL;
            soft_irq_level <= `IRSD_RST_VAL;
        end else begin
            if (hit_nir) begin
                reload_value <= req.wdata;
            end
            if (hit_tfo) begin
                flush_one_addr <= req.wdata;
            end
            if (hit_mce) begin
                mce_clear_data <= req.wdata;
            end
            if (hit_sir) begin
                soft_irq_level <= req.wdata;
            end
        end
    end

    // ==========================================
    // read path
    // read-only offsets ignore writes and read their source; write-only offsets read fixed value
    wire logic [31:0] ro_val =
        (ni == `IRSD_ICNT) ? icnt_r :
        (ni == `IRSD_CSC) ? csc_r :
        (ni == `IRSD_CSS) ? css_r :
        (ni == `IRSD_SYSID) ? `IRSD_SYSID_VAL : `IRSD_WO_READ;
    wire logic [31:0] nrm_val = (|rw_hit) ? rw_mux[NALL] : ro_val;

    logic nrd_r;
    logic [31:0] nrm_q;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rvalid <= 1'b0;
            rgroup <= IRSD_GRP_NORMAL;
            nrm_q <= `IRSD_RST_VAL;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                rgroup <= dec.grp;
                nrm_q <= nrm_val;
            end
        end
    end

    // rdata must be a flop output; tag/parity data are combinational reads and are registered here
    logic rd_d;
    irsd_group_t grp_d;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_d <= 1'b0;
            grp_d <= IRSD_GRP_NORMAL;
        end else begin
            rd_d <= req.rd;
            grp_d <= dec.grp;
        end
    end
    assign nrd_r = rd_d;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata <= `IRSD_WO_READ;
        end else if (req.rd) begin
            unique case (dec.grp)
                IRSD_GRP_NORMAL: rdata <= nrm_val;
                IRSD_GRP_TAG: rdata <= tag_rdata;
                IRSD_GRP_PARITY: rdata <= par_rdata;
                default: rdata <= `IRSD_WO_READ;
            endcase
        end
    end

    // ==========================================
    // checks
    tag_sort_a: assert property (@(posedge mclk) disable iff (!rst_n)
        req.rd |-> ((req.addr[`IRSD_GRP_HI] & ~req.addr[`IRSD_GRP_LO]) == sel_tag))
        else $error("tag group decode wrong");
    par_sort_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (req.addr[`IRSD_GRP_HI] & req.addr[`IRSD_GRP_LO]) |-> dec.grp == IRSD_GRP_PARITY)
        else $error("parity group decode wrong");
    grp_track_a: assert property (@(posedge mclk) disable iff (!rst_n)
        rvalid |-> nrd_r && rgroup == grp_d)
        else $error("read group not tracked");
    nrm_data_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (rvalid && rgroup == IRSD_GRP_NORMAL) |-> rdata == nrm_q)
        else $error("normal read data wrong");
    flush_all_a: assert property (@(posedge mclk) disable iff (!rst_n)
        hit_tfa |=> flush_all)
        else $error("flush all strobe missing");
    no_unmapped_a: assert property (@(posedge mclk) disable iff (!rst_n)
        sel_nrm | sel_tag | sel_par)
        else $error("address left unmapped");
    rv_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
        req.rd |=> rvalid && rgroup == $past(dec.grp))
        else $error("read answer missing");
    pbb_rw_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (nwr && ni == `IRSD_PBB) ##1 (req.rd && sel_nrm && ni == `IRSD_PBB && !req.wr)
        |=> rdata == $past(req.wdata, 2))
        else $error("process base readback wrong");
    reload_a: assert property (@(posedge mclk) disable iff (!rst_n)
        hit_nir |=> reload_load && reload_value == $past(req.wdata))
        else $error("reload strobe wrong");
    flush_one_a: assert property (@(posedge mclk) disable iff (!rst_n)
        flush_one |-> $past(nwr) && $past(ni) == `IRSD_TFO)
        else $error("flush strobe wrong");
    mce_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        hit_mce |=> mce_clear ##1 !mce_clear || $past(hit_mce))
        else $error("machine check clear strobe wrong");
    soft_irq_a: assert property (@(posedge mclk) disable iff (!rst_n)
        hit_sir |=> soft_irq_req && soft_irq_level == $past(req.wdata))
        else $error("soft interrupt strobe wrong");
    wo_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (req.rd && sel_nrm && (ni == `IRSD_NIR || ni == `IRSD_TFO)) |=> rdata == `IRSD_WO_READ)
        else $error("write-only read not fixed");
    ro_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (req.rd && sel_nrm && ni == `IRSD_CSC) |=> rdata == $past(csc_r))
        else $error("saved counter read wrong");
endmodule

// ===== tb_internal_register_space_decoder.sv
/*
 * self-checking bench for the register bank and its three-way decode.
 * assumes irsd_top, irsd_pkg and irsd_core_model are compiled first.
 */
`timescale 1ns/1ns
module tb_internal_register_space_decoder;
    import irsd_pkg::*;

    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    irsd_req_t req;
    logic [31:0] rdata, reload_value, flush_one_addr, mce_clear_data, soft_irq_level;
    logic rvalid, reload_load, flush_one, flush_all, mce_clear, soft_irq_req;
    irsd_group_t rgroup;
    int n_errors = 0;
    int checks_done = 0;
    int seed = 32'h7B01D42F;
    logic [34:0] exp_rd[$];
    logic [34:0] exp_st[$];
    logic [7:0] rw_list[25] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h09, 8'h0A,
        8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h12, 8'h13, 8'h15, 8'h18, 8'h1B,
        8'h38, 8'h3D, 8'h7A, 8'h7B, 8'h7D, 8'hA0};
    logic [7:0] ro_list[4] = '{8'h1A, 8'h2A, 8'h2B, 8'h3E};
    logic [7:0] wo_list[5] = '{8'h19, 8'h3A, 8'h39, 8'h26, 8'h14};
    logic [31:0] rw_val[25];
    logic [31:0] d, tag_last, par_last;
    int tag_idx[5] = '{0, 1, 127, 128, 255};
    int par_idx[5] = '{0, 1, 511, 512, 1023};

    always #20 mclk = ~mclk;

    irsd_top irsd_top_inst (
        .mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
        .rgroup(rgroup), .reload_value(reload_value), .reload_load(reload_load),
        .flush_one_addr(flush_one_addr), .flush_one(flush_one), .flush_all(flush_all),
        .mce_clear_data(mce_clear_data), .mce_clear(mce_clear),
        .soft_irq_level(soft_irq_level), .soft_irq_req(soft_irq_req)
    );

    irsd_core_model irsd_core_model_inst (
        .mclk(mclk),
        .req(req)
    );

    // ==========================================
    // compare and report
    task automatic cmp(input string name, input logic [34:0] e, input logic [34:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================
    // drivers: note the expectation, then issue
    task automatic rd(input logic [31:0] a, input irsd_group_t g, input logic [31:0] v);
        exp_rd.push_back({1'b0, g, v});
        irsd_core_model_inst.issue(1'b1, 1'b0, a, 32'h00000000);
    endtask

    // kind 0 means no strobe expected
    task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [2:0] k);
        if (k != 3'd0) exp_st.push_back({k, (k == 3'd3) ? 32'h00000000 : v});
        irsd_core_model_inst.issue(1'b0, 1'b1, a, v);
    endtask

    // ==========================================
    // monitor: an empty queue yields an impossible note
    task automatic take(ref logic [34:0] q[$], input string name, input logic [34:0] g);
        cmp(name, (q.size() != 0) ? q.pop_front() : 35'h7FFFFFFFF, g);
    endtask

    always @(posedge mclk) begin
        if (rvalid === 1'b1) take(exp_rd, "read", {1'b0, rgroup, rdata});
        if (reload_load === 1'b1) take(exp_st, "reload", {3'd1, reload_value});
        if (flush_one === 1'b1) take(exp_st, "flush one", {3'd2, flush_one_addr});
        if (flush_all === 1'b1) take(exp_st, "flush all", {3'd3, 32'h00000000});
        if (mce_clear === 1'b1) take(exp_st, "mce clear", {3'd4, mce_clear_data});
        if (soft_irq_req === 1'b1) take(exp_st, "soft irq", {3'd5, soft_irq_level});
    end

    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        conclude();
    end

    // ==========================================
    // main sequence
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rd(32'h00000010, IRSD_GRP_NORMAL, 32'h00000000);
        for (int i = 0; i < 25; i++) begin
            rw_val[i] = $random(seed);
            wr({24'h000000, rw_list[i]}, rw_val[i], 3'd0);
        end
        for (int i = 0; i < 25; i++) rd({24'h000000, rw_list[i]}, IRSD_GRP_NORMAL, rw_val[i]);
        d = $random(seed);
        wr(32'h00000010, d, 3'd0);
        rd(32'h00000010, IRSD_GRP_NORMAL, d);
        for (int i = 0; i < 4; i++) begin
            wr({24'h000000, ro_list[i]}, $random(seed), 3'd0);
            rd({24'h000000, ro_list[i]}, IRSD_GRP_NORMAL, 32'h00000000);
        end
        for (int i = 0; i < 5; i++) wr({24'h000000, wo_list[i]}, $random(seed), 3'(i + 1));
        for (int i = 0; i < 5; i++) rd({24'h000000, wo_list[i]}, IRSD_GRP_NORMAL, 32'h00000000);
        for (int i = 0; i < 5; i++) begin
            tag_last = $random(seed);
            wr(32'h01800000 + 32'(tag_idx[i]) * 32'h20, tag_last, 3'd0);
            rd(32'h01800000 + 32'(tag_idx[i]) * 32'h20, IRSD_GRP_TAG, tag_last);
        end
        for (int i = 0; i < 5; i++) begin
            par_last = $random(seed);
            wr(32'h01C00000 + 32'(par_idx[i]) * 32'h8, par_last, 3'd0);
            rd(32'h01C00000 + 32'(par_idx[i]) * 32'h8, IRSD_GRP_PARITY, par_last);
        end
        // unused bits set: tag and parity alias onto the last entries written, normal ones onto KSP and onto unmapped offset 05
        rd(32'hFF801FFF, IRSD_GRP_TAG, tag_last);
        rd(32'hFFFFFFF8, IRSD_GRP_PARITY, par_last);
        rd(32'h00400000, IRSD_GRP_NORMAL, rw_val[0]);
        rd(32'h00000105, IRSD_GRP_NORMAL, 32'h00000000);
        irsd_core_model_inst.idle();
        for (int k = 0; k < 10 && (exp_rd.size() + exp_st.size()) != 0; k++) @(posedge mclk);
        if ((exp_rd.size() + exp_st.size()) != 0) begin
            n_errors++;
            $display("unexpected pending notes expected 0 seen %0d", exp_rd.size() + exp_st.size());
        end
        conclude();
    end
endmodule
